//--- inc/rcctmr_pkg.sv
package rcctmr_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_IRQ_STS = 12'h004;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h008;
    localparam logic [11:0] OFS_COUNT   = 12'h00C;
    localparam logic [11:0] OFS_CLKCTL  = 12'h010;
    localparam logic [11:0] OFS_STAB    = 12'h014;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int BIT_TOP    = 7;
    localparam int BIT_IE     = 6;
    localparam int BIT_IF     = 5;
    localparam int BIT_CLR    = 4;
    localparam int SEL_LSB    = 0;
    localparam int SEL_W      = 4;

    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic       IE_RESET  = 1'b0;
    localparam int         IVL_BASE  = 8;   // select 0 -> 2^8 cycles

    // status / mask bits
    localparam int EV_INTERVAL = 0;
    localparam int EV_STABLE   = 1;
    localparam int EV_W        = 2;
    localparam logic [1:0] MSK_RESET = 2'h0;

    // clock-control register fields
    localparam int BIT_RC_EN   = 0;
    localparam int BIT_STOP    = 1;

    // stabilization wait select reset (2^STAB_RESET cycles)
    localparam logic [4:0] STAB_RESET = 5'h0F;

    // rc clock tick divider from the 100 MHz system clock
    localparam int RC_DIV_RESET = 1;

endpackage

//--- design/rcctmr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rcctmr_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // ------------------------------------------------------------------
    // two flops; the first is read only by the second
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule
`default_nettype wire

//--- design/rcctmr_div.sv
`timescale 1ns/1ns
`default_nettype none
module rcctmr_div
#(
    parameter int W = 8
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] ratio,
    output var  logic         tick
);

    logic [W-1:0] cnt_r;

    initial
    begin
        if (W < 1 || W > 16)
            $error("rcctmr_div: width out of range");
    end

    // ------------------------------------------------------------------
    // one-cycle enable every ratio+1 cycles
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end
        else if (cnt_r >= ratio)
        begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- design/rcctmr_top.sv
`timescale 1ns/1ns
`default_nettype none
module rcctmr_top
#(
    parameter int CNT_W = 23,
    parameter int DIV_W = 8
)
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output var  logic [31:0] HRDATA,
    output var  logic        HREADYOUT,
    output var  logic        HRESP,
    input  wire logic        EXTERNAL_RESET_N,
    input  wire logic        RC_OSC_RUNNING_MONITOR,
    output var  logic        RC_OSC_ENABLE,
    output var  logic        IRQ,
    output var  logic        INTERVAL_IRQ,
    output var  logic        RC_STABLE
);

    initial
    begin
        if (CNT_W != 23)
            $error("rcctmr_top: counter must be 23 bits");
        if (DIV_W < 1 || DIV_W > 16)
            $error("rcctmr_top: divider width out of range");
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic ext_rst_n_s;
    logic rc_mon_s;

    rcctmr_sync #(.W(2)) u_sync_pins
    (
        .clk  (CLK_SYS),
        .rst  (RST),
        .din  ({RC_OSC_RUNNING_MONITOR, EXTERNAL_RESET_N}),
        .dout ({rc_mon_s, ext_rst_n_s})
    );

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    localparam int EV_W_L = rcctmr_pkg::EV_W;
    logic [CNT_W-1:0] count_r;
    logic [3:0]       sel_r;
    logic             ie_r;
    logic             flag_r;
    logic [EV_W_L-1:0] sts_r;
    logic [EV_W_L-1:0] msk_r;
    logic             rc_en_r;
    logic             stop_r;
    logic [4:0]       stab_sel_r;
    logic [DIV_W-1:0] div_r;
    logic             carry_prev_r;
    logic             stab_prev_r;
    logic             rc_tick;
    logic             rc_active;
    logic             cnt_clear;

    // ------------------------------------------------------------------
    // rc clock tick: stands in for the rc oscillator edge
    // ------------------------------------------------------------------
    rcctmr_div #(.W(DIV_W)) u_div
    (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ratio (div_r),
        .tick  (rc_tick)
    );

    // ------------------------------------------------------------------
    // ahb-lite slave: address phase capture
    // ------------------------------------------------------------------
    logic        ap_wr_r;
    logic [11:0] ap_addr_r;
    logic        take;

    assign take = HSEL && HREADY && HTRANS[1];

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ap_wr_r   <= 1'b0;
            ap_addr_r <= '0;
        end
        else
        begin
            ap_wr_r   <= take && HWRITE;
            ap_addr_r <= take ? HADDR[11:0] : ap_addr_r;
        end
    end

    // decode used by both read and write paths
    function automatic logic hit
    (
        input logic [11:0] a,
        input logic [11:0] ofs
    );
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    logic wr_ctl;
    logic wr_sts;
    logic wr_msk;
    logic wr_clk;
    logic wr_stab;

    assign wr_ctl  = ap_wr_r && hit(ap_addr_r, rcctmr_pkg::OFS_CONTROL);
    assign wr_sts  = ap_wr_r && hit(ap_addr_r, rcctmr_pkg::OFS_IRQ_STS);
    assign wr_msk  = ap_wr_r && hit(ap_addr_r, rcctmr_pkg::OFS_IRQ_MSK);
    assign wr_clk  = ap_wr_r && hit(ap_addr_r, rcctmr_pkg::OFS_CLKCTL);
    assign wr_stab = ap_wr_r && hit(ap_addr_r, rcctmr_pkg::OFS_STAB);

    // zero-wait slave, always okay; same value in reset, so no reset branch
    always_ff @(posedge CLK_SYS)
    begin
        HREADYOUT <= 1'b1;
        HRESP     <= 1'b0;
    end

    // ------------------------------------------------------------------
    // clock control and software settings
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            rc_en_r    <= 1'b1;
            stop_r     <= 1'b0;
            stab_sel_r <= rcctmr_pkg::STAB_RESET;
            div_r      <= DIV_W'(rcctmr_pkg::RC_DIV_RESET);
        end
        else
        begin
            if (wr_clk)
            begin
                rc_en_r <= HWDATA[rcctmr_pkg::BIT_RC_EN];
                stop_r  <= HWDATA[rcctmr_pkg::BIT_STOP];
                div_r   <= HWDATA[8 +: DIV_W];
            end
            if (wr_stab)
                stab_sel_r <= HWDATA[4:0];
        end
    end

    // enable leaves the block as a plain registered level
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            RC_OSC_ENABLE <= 1'b1;
        else
            RC_OSC_ENABLE <= rc_en_r && !stop_r;
    end

    // stop clears at once; a disable clears only once the monitor agrees
    assign rc_active = !stop_r && !(!rc_en_r && !rc_mon_s);

    // ------------------------------------------------------------------
    // control register: enable and interval select
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST || !ext_rst_n_s)
        begin
            ie_r  <= rcctmr_pkg::IE_RESET;
            sel_r <= rcctmr_pkg::SEL_RESET;
        end
        else if (wr_ctl)
        begin
            // top bit is never stored, so rmw cannot touch it
            ie_r  <= HWDATA[rcctmr_pkg::BIT_IE];
            sel_r <= HWDATA[rcctmr_pkg::SEL_LSB +: rcctmr_pkg::SEL_W];
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    assign cnt_clear = !ext_rst_n_s
                     || !rc_active
                     || (wr_ctl && !HWDATA[rcctmr_pkg::BIT_CLR]);

    always_ff @(posedge CLK_SYS)
    begin
        if (RST || cnt_clear)
            count_r <= '0;
        else if (rc_tick)
            count_r <= count_r + 1'b1;
    end

    // ------------------------------------------------------------------
    // carry pick and edge detect
    // ------------------------------------------------------------------
    logic carry_bit;
    logic carry_rise;
    logic stab_bit;
    logic stab_rise;
    logic [4:0] ivl_idx;

    // select n carries out of bit 7+n, seen as that bit falling: the first
    // carry lands 2^(8+n) ticks after a clear, not half of that
    assign ivl_idx   = 5'(rcctmr_pkg::IVL_BASE - 1) + {1'b0, sel_r};
    assign carry_bit = count_r[ivl_idx];
    assign carry_rise = !carry_bit && carry_prev_r;

    // stabilization wait counts the same counter
    assign stab_bit  = count_r[stab_sel_r];
    assign stab_rise = stab_bit && !stab_prev_r;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST || cnt_clear)
        begin
            carry_prev_r <= 1'b0;
            stab_prev_r  <= 1'b0;
        end
        else
        begin
            carry_prev_r <= carry_bit && !wr_ctl;   // no carry on reselect
            stab_prev_r  <= stab_bit;
        end
    end

    // stable level: set on the first rise of the selected stab bit after release, cleared by any clear
    always_ff @(posedge CLK_SYS)
    begin
        if (RST || cnt_clear)
            RC_STABLE <= 1'b0;
        else if (stab_rise)
            RC_STABLE <= 1'b1;
    end

    // ------------------------------------------------------------------
    // interval flag: set wins over a clearing write
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST || !ext_rst_n_s)
            flag_r <= 1'b0;
        else if (carry_rise)
            flag_r <= 1'b1;
        else if (wr_ctl && !HWDATA[rcctmr_pkg::BIT_IF])
            flag_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // sticky status, write one to clear; set wins
    // ------------------------------------------------------------------
    logic [EV_W_L-1:0] ev;

    assign ev = {stab_rise, carry_rise};

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            sts_r <= '0;
        else
            sts_r <= ev | (sts_r & ~({EV_W_L{wr_sts}} & HWDATA[EV_W_L-1:0]));
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            msk_r <= rcctmr_pkg::MSK_RESET;
        else if (wr_msk)
            msk_r <= HWDATA[EV_W_L-1:0];
    end

    // ------------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            INTERVAL_IRQ <= 1'b0;
            IRQ          <= 1'b0;
        end
        else
        begin
            INTERVAL_IRQ <= flag_r && ie_r;
            IRQ          <= |(sts_r & msk_r);
        end
    end

    // ------------------------------------------------------------------
    // read data; the bus has no rmw, so the flag reads its true value
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit(HADDR[11:0], rcctmr_pkg::OFS_CONTROL))
        begin
            rd_mux[rcctmr_pkg::BIT_TOP] = 1'b0;
            rd_mux[rcctmr_pkg::BIT_IE]  = ie_r;
            rd_mux[rcctmr_pkg::BIT_IF]  = flag_r;
            rd_mux[rcctmr_pkg::BIT_CLR] = 1'b1;
            rd_mux[3:0]                 = sel_r;
        end
        else if (hit(HADDR[11:0], rcctmr_pkg::OFS_IRQ_STS))
            rd_mux[EV_W_L-1:0] = sts_r;
        else if (hit(HADDR[11:0], rcctmr_pkg::OFS_IRQ_MSK))
            rd_mux[EV_W_L-1:0] = msk_r;
        else if (hit(HADDR[11:0], rcctmr_pkg::OFS_COUNT))
            rd_mux[CNT_W-1:0] = count_r;
        else if (hit(HADDR[11:0], rcctmr_pkg::OFS_CLKCTL))
        begin
            rd_mux[rcctmr_pkg::BIT_RC_EN] = rc_en_r;
            rd_mux[rcctmr_pkg::BIT_STOP]  = stop_r;
            rd_mux[2]                     = rc_mon_s;
            rd_mux[3]                     = RC_STABLE;
            rd_mux[8 +: DIV_W]            = div_r;
        end
        else if (hit(HADDR[11:0], rcctmr_pkg::OFS_STAB))
            rd_mux[4:0] = stab_sel_r;
    end

    // rdata is latched at the end of the address phase edge
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            HRDATA <= 32'h0000_0000;
        else if (take && !HWRITE)
            HRDATA <= rd_mux;
    end

endmodule
`default_nettype wire

//--- bench/rcctmr_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// port checks of the rc interval timer
// ------------------------------------------------
module rcctmr_top_checker
(
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        EXTERNAL_RESET_N,
    input wire logic        RC_OSC_ENABLE,
    input wire logic        IRQ,
    input wire logic        INTERVAL_IRQ,
    input wire logic        RC_STABLE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // accepted address phases, upper address bits must be zero
    sequence s_rd(logic [11:0] ofs);
        HSEL && HREADY && HTRANS[1] && !HWRITE
            && HADDR == {20'h0_0000, ofs};
    endsequence
    sequence s_wr(logic [11:0] ofs);
        HSEL && HREADY && HTRANS[1] && HWRITE
            && HADDR == {20'h0_0000, ofs};
    endsequence
    sequence s_ext_low;
        !EXTERNAL_RESET_N [*6];
    endsequence

    property p_ready;
        HREADYOUT && !HRESP;
    endproperty
    property p_rst_out;
        $past(RST) |-> !IRQ && !INTERVAL_IRQ && !RC_STABLE && RC_OSC_ENABLE;
    endproperty
    // two sync flops plus output register fit inside six cycles
    property p_ext_hold;
        s_ext_low |=> !INTERVAL_IRQ && !RC_STABLE;
    endproperty
    property p_clr_read;
        s_rd(rcctmr_pkg::OFS_CONTROL) |=> HRDATA[rcctmr_pkg::BIT_CLR]
            && !HRDATA[rcctmr_pkg::BIT_TOP];
    endproperty
    property p_unmapped;
        s_rd(12'h018) |=> HRDATA == 32'h0000_0000;
    endproperty
    // register updates at the data phase edge, the output one edge later
    property p_ie_off;
        s_wr(rcctmr_pkg::OFS_CONTROL) ##1 !HWDATA[rcctmr_pkg::BIT_IE]
            |=> ##1 !INTERVAL_IRQ;
    endproperty
    property p_mask_off;
        s_wr(rcctmr_pkg::OFS_IRQ_MSK) ##1 HWDATA[1:0] == 2'h0 |=> ##1 !IRQ;
    endproperty
    property p_stop;
        s_wr(rcctmr_pkg::OFS_CLKCTL) ##1 HWDATA[rcctmr_pkg::BIT_STOP]
            |=> ##1 !RC_OSC_ENABLE;
    endproperty

    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
    a_ext_hold: assert property (p_ext_hold) else $error("ext reset hold");
    a_clr_read: assert property (p_clr_read) else $error("control read bits");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_ie_off: assert property (p_ie_off) else $error("irq with enable off");
    a_mask_off: assert property (p_mask_off) else $error("irq with mask off");
    a_stop: assert property (p_stop) else $error("rc enable in stop");
endmodule

bind rcctmr_top rcctmr_top_checker u_chk
(
    .CLK_SYS          (CLK_SYS),
    .RST              (RST),
    .HSEL             (HSEL),
    .HADDR            (HADDR),
    .HTRANS           (HTRANS),
    .HWRITE           (HWRITE),
    .HWDATA           (HWDATA),
    .HREADY           (HREADY),
    .HRDATA           (HRDATA),
    .HREADYOUT        (HREADYOUT),
    .HRESP            (HRESP),
    .EXTERNAL_RESET_N (EXTERNAL_RESET_N),
    .RC_OSC_ENABLE    (RC_OSC_ENABLE),
    .IRQ              (IRQ),
    .INTERVAL_IRQ     (INTERVAL_IRQ),
    .RC_STABLE        (RC_STABLE)
);
`default_nettype wire

//--- bench/rcctmr_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// register level bench of the rc interval timer
// ------------------------------------------------
module rcctmr_top_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        ext_rst_n = 1'b1;
    logic        mon = 1'b1;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         rc_en;
    wire         irq;
    wire         iv_irq;
    wire         stable;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    rcctmr_top dut
    (
        .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(), .EXTERNAL_RESET_N(ext_rst_n),
        .RC_OSC_RUNNING_MONITOR(mon), .RC_OSC_ENABLE(rc_en), .IRQ(irq),
        .INTERVAL_IRQ(iv_irq), .RC_STABLE(stable)
    );

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // cycle count doubles as hang guard; worst case stable wait is ~33k
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            err_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one single-word transfer; address held until hready is sampled
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask

    // the output is registered two edges after a clearing write
    task automatic wait_iv(output int t);
        int k;
        k = 0;
        repeat (2) @(posedge clk_sys);
        while (iv_irq !== 1'b1 && k < 5000)
        begin
            @(posedge clk_sys);
            k++;
        end
        t = cycles;
    endtask

    // main sequence
    initial
    begin
        logic [31:0] q;
        int          t0;
        int          t1;
        int          t2;
        int          t3;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(rcctmr_pkg::OFS_CONTROL, 32'h0000_0010);
        rdchk(rcctmr_pkg::OFS_IRQ_STS, 32'h0000_0000);
        rdchk(rcctmr_pkg::OFS_IRQ_MSK, 32'h0000_0000);
        rdchk(rcctmr_pkg::OFS_CLKCTL, 32'h0000_0105);
        rdchk(12'h018, 32'h0000_0000);
        wr(rcctmr_pkg::OFS_CLKCTL, 32'h0000_0001);
        wr(rcctmr_pkg::OFS_STAB, 32'h0000_0006);
        wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0000);
        bus(1'b0, rcctmr_pkg::OFS_COUNT, 32'h0000_0000, q);
        check({31'h0, q < 32'd8}, 32'h1);
        wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0030);
        rdchk(rcctmr_pkg::OFS_CONTROL, 32'h0000_0010);
        repeat (100) @(posedge clk_sys);
        bus(1'b0, rcctmr_pkg::OFS_COUNT, 32'h0000_0000, q);
        check({31'h0, q >= 32'd100 && q <= 32'd125}, 32'h1);
        // period between two flag sets, flag cleared without counter clear
        for (int s = 0; s < 4; s++)
        begin
            wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0050 | 32'(s));
            wait_iv(t0);
            wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0050 | 32'(s));
            wait_iv(t1);
            check(32'(t1 - t0), 32'h1 << (8 + s));
        end
        bus(1'b0, rcctmr_pkg::OFS_IRQ_STS, 32'h0000_0000, q);
        check({31'h0, q[0]}, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(rcctmr_pkg::OFS_IRQ_MSK, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        wr(rcctmr_pkg::OFS_IRQ_STS, 32'h0000_0003);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        wr(rcctmr_pkg::OFS_IRQ_MSK, 32'h0000_0000);
        // a clear at another phase gives the same first interval
        wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0040);
        t0 = cycles;
        wait_iv(t1);
        repeat (37) @(posedge clk_sys);
        wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0040);
        t2 = cycles;
        wait_iv(t3);
        check(32'(t3 - t2), 32'(t1 - t0));
        // first interval after a clear is the full 2^8, plus a short pipeline
        t1 = t1 - t0 - (1 << rcctmr_pkg::IVL_BASE);
        check({31'h0, t1 >= 0 && t1 < 8}, 32'h1);
        wr(rcctmr_pkg::OFS_CLKCTL, 32'h0000_0003);
        repeat (2) @(posedge clk_sys);
        check({31'h0, rc_en}, 32'h0);
        rdchk(rcctmr_pkg::OFS_COUNT, 32'h0000_0000);
        wr(rcctmr_pkg::OFS_CLKCTL, 32'h0000_0001);
        repeat (20) @(posedge clk_sys);
        wr(rcctmr_pkg::OFS_CLKCTL, 32'h0000_0000);
        bus(1'b0, rcctmr_pkg::OFS_COUNT, 32'h0000_0000, q);
        check({31'h0, q != 32'h0}, 32'h1);
        mon <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdchk(rcctmr_pkg::OFS_COUNT, 32'h0000_0000);
        mon <= 1'b1;
        wr(rcctmr_pkg::OFS_CLKCTL, 32'h0000_0001);
        wr(rcctmr_pkg::OFS_CONTROL, 32'h0000_0053);
        ext_rst_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check({31'h0, stable}, 32'h0);
        rdchk(rcctmr_pkg::OFS_COUNT, 32'h0000_0000);
        rdchk(rcctmr_pkg::OFS_CONTROL, 32'h0000_0010);
        ext_rst_n <= 1'b1;
        t0 = cycles;
        while (stable !== 1'b1 && cycles - t0 < 40000)
            @(posedge clk_sys);
        check({31'h0, stable === 1'b1 && cycles - t0 >= 64}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
